//--- nv_ctrl_defs.svh
// Offsets, bit positions, reset values and opcodes of the NV control block.
`ifndef NV_CTRL_DEFS_SVH
`define NV_CTRL_DEFS_SVH
`define OFS_STATUS_PIN_CTRL 12'h232
`define OFS_POWER_DOWN 12'h233
`define OFS_UPDATE 12'h234
`define OFS_SEG_FIRST 12'hA00
`define OFS_SEG_LAST 12'hA16
`define OFS_NV_STATUS 12'hB00
`define OFS_NV_ERROR 12'hB01
`define OFS_NV_CTRL_ONE 12'hB02
`define OFS_NV_CTRL_TWO 12'hB03
`define BIT_PD_INPUT_PLL 2
`define BIT_PD_DISTRIB 0
`define BIT_STATUS_PIN_ZERO_NV_EN 4
`define BIT_UPDATE 0
`define BIT_NV_WRITE_EN 0
`define BIT_SOFT_RESTORE 1
`define BIT_SAVE 0
`define RST_POWER_DOWN 8'h05
`define RST_STATUS_PIN_CTRL 8'h00
`define SEG_ENTRIES 23
`define OP_APPLY_UPDATE 8'h80
`define OP_END_OF_DATA 8'hFF
`define SEG_COUNT_MSB 6
`define SEG_AHI_MSB 3
`define SEG_DEF0 8'h7F
`define SEG_DEF1 8'h00
`define SEG_DEF2 8'h00
`define SEG_DEF3 8'h7F
`define SEG_DEF4 8'h02
`define SEG_DEF5 8'h00
`endif

//--- nv_ctrl_pkg.sv
// Types shared by the NV control block and its surroundings.
`default_nettype none
package nv_ctrl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } buf_wr_s;
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } nv_word_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_ADDR_HI, ST_ADDR_LO, ST_MOVE, ST_FLUSH
  } walk_e;
endpackage
`default_nettype wire

//--- nv_ctrl.sv
// Settings update and nonvolatile store/restore controller.
//
// Contract
// - Power-down register holds input PLL and distribution bits, reset 1.
// - Update bit copies all staged registers to active on next SCLK rise.
// - Update bit clears itself after the copy.
// - Segment table holds 12-bit start addresses and byte counts.
// - Segment table also holds apply-update and end-of-data opcodes.
// - Default table moves two 128-byte segments, at 0x000 and 0x200, then issues an apply-update.
// - Transfer-pending bit reads 1 while NV data is moving.
// - Transfer-pending drives status pin 0 when its enable bit is set.
// - Data-error bit reads 1 when a bad word arrives from the store.
// - With boot-select low, soft bit restores from store; self clears.
// - Write-enable bit resets 0 and blocks any save until set.
// - Writing 1 to the save bit starts copying buffer into the store.
// - Save bit is cleared by the controller when the save finishes.
// - Status-pin control bit 4 routes NV pending to status pin 0.
`include "nv_ctrl_defs.svh"
`default_nettype none
module nv_ctrl
  import nv_ctrl_pkg::*;
#(
  parameter int ENTRIES = `SEG_ENTRIES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sclk_rise_i,
  input wire logic boot_sel_n_i,
  output logic [7:0] active_status_ctrl_o,
  output logic pd_input_pll_o,
  output logic pd_distrib_o,
  output logic update_pulse_o,
  output logic soft_reset_o,
  output logic status_pin_zero_o,
  output logic [11:0] buf_raddr_o,
  input wire logic [7:0] buf_rdata_i,
  output buf_wr_s buf_wr_o,
  output logic nv_start_o,
  output logic nv_save_o,
  output nv_word_s nv_wword_o,
  output logic nv_wvalid_o,
  input wire logic nv_wready_i,
  input wire nv_word_s nv_rword_i,
  input wire logic nv_rvalid_i,
  output logic nv_rready_o
);

  // Register file: staged copies, active copies and the segment table.
  logic [7:0] stg_status, next_stg_status, stg_pd, next_stg_pd;
  logic [7:0] act_status, next_act_status, act_pd, next_act_pd;
  logic upd_pend, next_upd_pend;
  logic wr_en, next_wr_en, save_bit, next_save_bit;
  logic soft_bit, next_soft_bit, err_bit, next_err_bit;
  logic [7:0] rdata, next_rdata;
  logic [7:0] seg_tab [ENTRIES];
  logic [7:0] next_seg_tab [ENTRIES];
  logic start_save, start_restore, walk_done, apply_req, bad_word;
  logic pending;

  logic wr_hit_update, wr_hit_ctrl1, wr_hit_ctrl2;
  assign wr_hit_update = reg_req_i.wr && reg_req_i.addr == `OFS_UPDATE;
  assign wr_hit_ctrl1 = reg_req_i.wr && reg_req_i.addr == `OFS_NV_CTRL_ONE;
  assign wr_hit_ctrl2 = reg_req_i.wr && reg_req_i.addr == `OFS_NV_CTRL_TWO;

  // Save only when writes are enabled and nothing else is running.
  assign start_save = wr_hit_ctrl2 && reg_req_i.wdata[`BIT_SAVE] &&
                      wr_en && !pending;
  assign start_restore = wr_hit_ctrl1 && reg_req_i.wdata[`BIT_SOFT_RESTORE] &&
                         !boot_sel_n_i && !pending;

  always_comb begin
    next_stg_status = stg_status;
    next_stg_pd = stg_pd;
    next_act_status = act_status;
    next_act_pd = act_pd;
    next_wr_en = wr_en;
    next_save_bit = save_bit;
    next_soft_bit = soft_bit;
    next_err_bit = err_bit;
    next_upd_pend = upd_pend;
    next_seg_tab = seg_tab;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        `OFS_STATUS_PIN_CTRL: next_stg_status = reg_req_i.wdata;
        `OFS_POWER_DOWN: next_stg_pd = reg_req_i.wdata;
        `OFS_NV_CTRL_ONE: begin
          next_wr_en = reg_req_i.wdata[`BIT_NV_WRITE_EN];
        end
        default: begin
          if (reg_req_i.addr >= `OFS_SEG_FIRST &&
              reg_req_i.addr <= `OFS_SEG_LAST) begin
            next_seg_tab[5'(reg_req_i.addr - `OFS_SEG_FIRST)] =
              reg_req_i.wdata;
          end
        end
      endcase
    end
    // The copy happens on an SCLK rise; a request in that cycle waits.
    if (upd_pend && sclk_rise_i) begin
      next_act_status = stg_status;
      next_act_pd = stg_pd;
      next_upd_pend = 1'b0;
    end
    if ((wr_hit_update && reg_req_i.wdata[`BIT_UPDATE]) || apply_req) begin
      next_upd_pend = 1'b1;
    end
    if (walk_done) begin
      next_save_bit = 1'b0;
      next_soft_bit = 1'b0;
    end
    if (start_save) begin
      next_save_bit = 1'b1;
      next_err_bit = 1'b0;
    end
    if (start_restore) begin
      next_soft_bit = 1'b1;
      next_err_bit = 1'b0;
    end
    if (bad_word) begin
      next_err_bit = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `OFS_STATUS_PIN_CTRL: next_rdata = stg_status;
        `OFS_POWER_DOWN: next_rdata = stg_pd;
        `OFS_UPDATE: next_rdata = {7'h00, upd_pend};
        `OFS_NV_STATUS: next_rdata = {7'h00, pending};
        `OFS_NV_ERROR: next_rdata = {7'h00, err_bit};
        `OFS_NV_CTRL_ONE: next_rdata = {6'h00, soft_bit, wr_en};
        `OFS_NV_CTRL_TWO: next_rdata = {7'h00, save_bit};
        default: begin
          if (reg_req_i.addr >= `OFS_SEG_FIRST &&
              reg_req_i.addr <= `OFS_SEG_LAST) begin
            next_rdata = seg_tab[5'(reg_req_i.addr - `OFS_SEG_FIRST)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stg_status <= `RST_STATUS_PIN_CTRL;
      stg_pd <= `RST_POWER_DOWN;
      act_status <= `RST_STATUS_PIN_CTRL;
      act_pd <= `RST_POWER_DOWN;
      upd_pend <= 1'b0;
      wr_en <= 1'b0;
      save_bit <= 1'b0;
      soft_bit <= 1'b0;
      err_bit <= 1'b0;
      rdata <= 8'h00;
      for (int i = 0; i < ENTRIES; i++) begin
        seg_tab[i] <= `OP_END_OF_DATA;
      end
      // Two 128-byte segments, at 0x000 and 0x200, then apply-update, then end.
      seg_tab[0] <= `SEG_DEF0;
      seg_tab[1] <= `SEG_DEF1;
      seg_tab[2] <= `SEG_DEF2;
      seg_tab[3] <= `SEG_DEF3;
      seg_tab[4] <= `SEG_DEF4;
      seg_tab[5] <= `SEG_DEF5;
      seg_tab[6] <= `OP_APPLY_UPDATE;
    end else begin
      stg_status <= next_stg_status;
      stg_pd <= next_stg_pd;
      act_status <= next_act_status;
      act_pd <= next_act_pd;
      upd_pend <= next_upd_pend;
      wr_en <= next_wr_en;
      save_bit <= next_save_bit;
      soft_bit <= next_soft_bit;
      err_bit <= next_err_bit;
      rdata <= next_rdata;
      seg_tab <= next_seg_tab;
    end
  end

  // Two-entry buffer between the buffer bank and the store's write port.
  nv_word_s fifo_mem [2];
  nv_word_s next_fifo_mem [2];
  logic fifo_wp, next_fifo_wp, fifo_rp, next_fifo_rp;
  logic [1:0] fifo_cnt, next_fifo_cnt;
  logic fifo_push, fifo_pop, fifo_full;
  assign fifo_full = fifo_cnt == 2'd2;
  assign fifo_pop = nv_wvalid_o && nv_wready_i;
  assign nv_wvalid_o = fifo_cnt != 2'd0;
  assign nv_wword_o = fifo_mem[fifo_rp];

  always_comb begin
    next_fifo_mem = fifo_mem;
    next_fifo_wp = fifo_wp;
    next_fifo_rp = fifo_rp;
    next_fifo_cnt = fifo_cnt;
    if (fifo_push) begin
      next_fifo_mem[fifo_wp] = '{err: 1'b0, data: buf_rdata_i};
      next_fifo_wp = ~fifo_wp;
    end
    if (fifo_pop) begin
      next_fifo_rp = ~fifo_rp;
    end
    next_fifo_cnt = 2'(fifo_cnt + {1'b0, fifo_push} - {1'b0, fifo_pop});
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
      fifo_wp <= 1'b0;
      fifo_rp <= 1'b0;
      fifo_cnt <= 2'd0;
    end else begin
      fifo_mem <= next_fifo_mem;
      fifo_wp <= next_fifo_wp;
      fifo_rp <= next_fifo_rp;
      fifo_cnt <= next_fifo_cnt;
    end
  end

  // Table walker.
  walk_e state, next_state;
  logic [4:0] idx, next_idx;
  logic [6:0] cnt, next_cnt;
  logic [11:0] addr, next_addr;
  logic dir_save, next_dir_save, next_nv_start, next_soft_reset;
  buf_wr_s next_buf_wr;
  logic [7:0] entry;
  assign entry = seg_tab[idx];
  assign pending = state != ST_IDLE;
  assign nv_rready_o = state == ST_MOVE && !dir_save;
  assign bad_word = nv_rvalid_i && nv_rready_o && nv_rword_i.err;

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_cnt = cnt;
    next_addr = addr;
    next_dir_save = dir_save;
    next_nv_start = 1'b0;
    next_soft_reset = 1'b0;
    next_buf_wr = '{we: 1'b0, addr: buf_wr_o.addr, data: buf_wr_o.data};
    fifo_push = 1'b0;
    apply_req = 1'b0;
    walk_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_save || start_restore) begin
          next_state = ST_FETCH;
          next_idx = 5'd0;
          next_dir_save = start_save;
          next_nv_start = 1'b1;
          next_soft_reset = start_restore;
        end
      end
      ST_FETCH: begin
        if (idx == 5'(ENTRIES) || entry == `OP_END_OF_DATA) begin
          next_state = ST_FLUSH;
        end else if (entry == `OP_APPLY_UPDATE) begin
          apply_req = 1'b1;
          next_idx = 5'(idx + 5'd1);
        end else begin
          next_cnt = entry[`SEG_COUNT_MSB:0];
          next_idx = 5'(idx + 5'd1);
          next_state = ST_ADDR_HI;
        end
      end
      ST_ADDR_HI: begin
        next_addr[11:8] = entry[`SEG_AHI_MSB:0];
        next_idx = 5'(idx + 5'd1);
        next_state = ST_ADDR_LO;
      end
      ST_ADDR_LO: begin
        next_addr[7:0] = entry;
        next_idx = 5'(idx + 5'd1);
        next_state = ST_MOVE;
      end
      ST_MOVE: begin
        if (dir_save) begin
          fifo_push = !fifo_full;
        end else if (nv_rvalid_i) begin
          next_buf_wr = '{we: 1'b1, addr: addr, data: nv_rword_i.data};
        end
        if (fifo_push || (!dir_save && nv_rvalid_i)) begin
          next_addr = 12'(addr + 12'd1);
          next_cnt = 7'(cnt - 7'd1);
          if (cnt == 7'd0) begin
            next_state = ST_FETCH;
          end
        end
      end
      ST_FLUSH: begin
        // A save ends only when the last word has left the buffer.
        if (fifo_cnt == 2'd0) begin
          walk_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      idx <= 5'd0;
      cnt <= 7'd0;
      addr <= 12'h000;
      dir_save <= 1'b0;
      nv_start_o <= 1'b0;
      soft_reset_o <= 1'b0;
      buf_wr_o <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      cnt <= next_cnt;
      addr <= next_addr;
      dir_save <= next_dir_save;
      nv_start_o <= next_nv_start;
      soft_reset_o <= next_soft_reset;
      buf_wr_o <= next_buf_wr;
    end
  end

  assign reg_rdata_o = rdata;
  assign buf_raddr_o = addr;
  assign nv_save_o = dir_save;
  assign active_status_ctrl_o = act_status;
  assign pd_input_pll_o = act_pd[`BIT_PD_INPUT_PLL];
  assign pd_distrib_o = act_pd[`BIT_PD_DISTRIB];
  assign update_pulse_o = upd_pend && sclk_rise_i;
  assign status_pin_zero_o = act_status[`BIT_STATUS_PIN_ZERO_NV_EN] &&
                             pending;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_copy;
    upd_pend && sclk_rise_i |=>
      act_pd == $past(stg_pd) && act_status == $past(stg_status);
  endproperty
  a_copy: assert property (p_copy)
    else $error("update copy failed");

  // A new update request in the copy cycle wins, so only then may it stay.
  property p_self_clear;
    upd_pend && sclk_rise_i && !apply_req &&
      !(wr_hit_update && reg_req_i.wdata[`BIT_UPDATE]) |=> !upd_pend;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("update bit stuck");

  property p_no_copy;
    !(upd_pend && sclk_rise_i) |=> $stable(act_pd);
  endproperty
  a_no_copy: assert property (p_no_copy)
    else $error("active changed without update");

  property p_protect;
    !wr_en && !save_bit |=> !save_bit;
  endproperty
  a_protect: assert property (p_protect)
    else $error("save while protected");

  property p_save_start;
    start_save |=> save_bit && pending && nv_save_o;
  endproperty
  a_save_start: assert property (p_save_start)
    else $error("save did not start");

  property p_save_end;
    save_bit && state == ST_FLUSH && fifo_cnt == 2'd0 |=>
      !save_bit && !pending;
  endproperty
  a_save_end: assert property (p_save_end)
    else $error("save bit not cleared");

  property p_pin;
    status_pin_zero_o ==
      (act_status[`BIT_STATUS_PIN_ZERO_NV_EN] && state != ST_IDLE);
  endproperty
  a_pin: assert property (p_pin)
    else $error("status pin wrong");

  property p_err;
    nv_rvalid_i && nv_rready_o && nv_rword_i.err |=> err_bit;
  endproperty
  a_err: assert property (p_err)
    else $error("error not flagged");

  property p_soft;
    start_restore |=> soft_reset_o ##0 soft_bit ##0 !nv_save_o;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft restore did not start");

  property p_end;
    state == ST_FETCH && entry == `OP_END_OF_DATA |=> state == ST_FLUSH;
  endproperty
  a_end: assert property (p_end)
    else $error("end marker not honoured");

endmodule
`default_nettype wire

//--- nv_store_model.sv
// Nonvolatile store and buffer bank model facing the NV control block.
`default_nettype none
module nv_store_model
  import nv_ctrl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic bad_word_i,
  input wire nv_word_s nv_wword_i,
  input wire logic nv_wvalid_i,
  output logic nv_wready_o,
  output nv_word_s nv_rword_o,
  output logic nv_rvalid_o,
  input wire logic nv_rready_i,
  input wire logic [11:0] buf_raddr_i,
  output logic [7:0] buf_rdata_o,
  input wire buf_wr_s buf_wr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] saved [$];
  logic [7:0] rcnt;
  logic [11:0] last_waddr;
  logic [7:0] last_wdata;
  int n_buf_wr;
  logic phase;
  assign buf_rdata_o = buf_raddr_i[7:0] ^ 8'hA5;
  // A slow store stalls every other cycle so the two-entry buffer fills.
  assign nv_wready_o = !slow_i || phase;
  assign nv_rvalid_o = !slow_i || phase;
  // Between valid words the byte is inverted so stale data never matches.
  assign nv_rword_o = '{err: nv_rvalid_o && bad_word_i && rcnt == 8'h01,
                        data: nv_rvalid_o ? rcnt : ~rcnt};
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= 1'b0;
      rcnt <= 8'h00;
      n_buf_wr <= 0;
    end else begin
      phase <= !phase;
      if (nv_wvalid_i && nv_wready_o) begin
        saved.push_back(nv_wword_i.data);
      end
      if (nv_rvalid_o && nv_rready_i) begin
        rcnt <= rcnt + 8'h01;
      end
      if (buf_wr_i.we) begin
        n_buf_wr <= n_buf_wr + 1;
        last_waddr <= buf_wr_i.addr;
        last_wdata <= buf_wr_i.data;
      end
    end
  end
endmodule
`default_nettype wire

//--- test_nv_ctrl.sv
// Self-checking testbench for the NV control block.
`default_nettype none
module test_nv_ctrl;
  import nv_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, resetn_i, sclk_rise_i, boot_sel_n_i, slow, bad_word;
  logic pd_pll, pd_dist, upd, soft_rst, stat0, nv_start, nv_save;
  logic wvalid, wready, rvalid, rready;
  logic [7:0] rdata, active_sc, brdata, v;
  logic [11:0] raddr;
  reg_req_s req;
  buf_wr_s bwr;
  nv_word_s wword, rword;
  int fail_count = 0;
  int n_compared = 0;

  nv_ctrl u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .sclk_rise_i(sclk_rise_i),
    .boot_sel_n_i(boot_sel_n_i), .active_status_ctrl_o(active_sc),
    .pd_input_pll_o(pd_pll), .pd_distrib_o(pd_dist),
    .update_pulse_o(upd), .soft_reset_o(soft_rst),
    .status_pin_zero_o(stat0), .buf_raddr_o(raddr), .buf_rdata_i(brdata),
    .buf_wr_o(bwr), .nv_start_o(nv_start), .nv_save_o(nv_save),
    .nv_wword_o(wword), .nv_wvalid_o(wvalid), .nv_wready_i(wready),
    .nv_rword_i(rword), .nv_rvalid_i(rvalid), .nv_rready_o(rready));

  nv_store_model u_store (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .slow_i(slow), .bad_word_i(bad_word), .nv_wword_i(wword),
    .nv_wvalid_i(wvalid), .nv_wready_o(wready), .nv_rword_o(rword),
    .nv_rvalid_o(rvalid), .nv_rready_i(rready), .buf_raddr_i(raddr),
    .buf_rdata_o(brdata), .buf_wr_i(bwr));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req = '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_i);
    req = '0;
    d = rdata;
  endtask

  // Polls a register until the masked bits drop, with a bounded wait.
  task automatic wait_clear(input logic [11:0] a, input logic [7:0] m);
    int i;
    for (i = 0; i < 300; i++) begin
      rd(a, v);
      if ((v & m) === 8'h00) break;
    end
    check(v & m, 8'h00, "command bit still set");
  endtask

  // Gives one serial clock rise and checks whether a copy took place.
  task automatic sclk_pulse(input logic exp_upd);
    @(negedge clk_sys_i);
    sclk_rise_i = 1'b1;
    #1;
    check({7'h00, upd}, {7'h00, exp_upd}, "update pulse");
    @(negedge clk_sys_i);
    sclk_rise_i = 1'b0;
  endtask

  task automatic t_reset();
    check({6'h00, pd_pll, pd_dist}, 8'h03, "pd after reset");
    rd(12'h233, v);
    check(v, 8'h05, "power-down reset");
    rd(12'hB00, v);
    check(v, 8'h00, "idle pending");
    rd(12'hB02, v);
    check(v, 8'h00, "control one reset");
  endtask

  task automatic t_update();
    wr(12'h233, 8'h00);
    wr(12'h232, 8'h10);
    sclk_pulse(1'b0);
    check({7'h00, pd_pll}, 8'h01, "staged only");
    wr(12'h234, 8'h01);
    rd(12'h234, v);
    check(v, 8'h01, "update bit set");
    sclk_pulse(1'b1);
    check({6'h00, pd_pll, pd_dist}, 8'h00, "pd active");
    check(active_sc, 8'h10, "active status ctrl");
    rd(12'h234, v);
    check(v, 8'h00, "update self clear");
  endtask

  task automatic t_table();
    logic [7:0] def [8] = '{8'h7F, 8'h00, 8'h00, 8'h7F, 8'h02, 8'h00,
      8'h80, 8'hFF};
    for (int i = 0; i < 8; i++) begin
      rd(12'hA00 + 12'(i), v);
      check(v, def[i], "default table");
    end
    wr(12'hA00, 8'h02);
    wr(12'hA01, 8'h00);
    wr(12'hA02, 8'h10);
    wr(12'hA03, 8'hFF);
    rd(12'hA02, v);
    check(v, 8'h10, "table readback");
  endtask

  task automatic t_save();
    wr(12'hB03, 8'h01);
    check({7'h00, nv_start}, 8'h00, "save blocked");
    slow = 1'b1;
    wr(12'hB02, 8'h01);
    wr(12'hB03, 8'h01);
    check({6'h00, nv_start, nv_save}, 8'h03, "save start");
    check({7'h00, stat0}, 8'h01, "status pin busy");
    rd(12'hB00, v);
    check(v, 8'h01, "pending");
    wait_clear(12'hB03, 8'h01);
    check(8'(u_store.saved.size()), 8'h03, "saved count");
    for (int i = 0; i < 3; i++) begin
      check(u_store.saved[i], 8'(8'h10 + i) ^ 8'hA5,
        "saved byte");
    end
    rd(12'hB00, v);
    check(v, 8'h00, "done");
    check({7'h00, stat0}, 8'h00, "status pin idle");
  endtask

  task automatic t_restore();
    wr(12'hB02, 8'h03);
    check({7'h00, soft_rst}, 8'h00, "restore blocked");
    rd(12'hB02, v);
    check(v, 8'h01, "soft bit refused");
    wr(12'hA00, 8'h01);
    wr(12'hA03, 8'h80);
    wr(12'hA04, 8'hFF);
    bad_word = 1'b1;
    boot_sel_n_i = 1'b0;
    wr(12'hB02, 8'h03);
    check({6'h00, soft_rst, nv_start}, 8'h03, "restore start");
    wait_clear(12'hB02, 8'h02);
    check(8'(u_store.n_buf_wr), 8'h02, "restored count");
    check(u_store.last_waddr[7:0], 8'h11, "restore addr");
    check(u_store.last_wdata, 8'h01, "restore data");
    rd(12'hB01, v);
    check(v, 8'h01, "data error");
    sclk_pulse(1'b1);
  endtask

  initial begin
    req = '0;
    sclk_rise_i = 1'b0;
    boot_sel_n_i = 1'b1;
    slow = 1'b0;
    bad_word = 1'b0;
    resetn_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_reset();
    t_update();
    t_table();
    t_save();
    t_restore();
    report_and_stop();
  end

  // The whole run needs about a hundred cycles; this leaves ample margin.
  initial begin
    #200000;
    fail_count++;
    $display("FAIL at %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
